/* File: hw/pims_regs.sv */
// port phy interrupt enable and special control/status register bank
`timescale 1ns/10ps
`default_nettype none
module pims_regs
    import pims_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // management register port
    input wire logic [4:0] reg_index,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    // phy status pins
    input wire logic [7:1] phy_event,
    input wire logic autoneg_done,
    input wire logic [2:0] speed_duplex,
    // interrupt request
    output logic phy_irq
);
    // ********************************
    // pin synchronisation
    // ********************************
    logic [PIMS_SYNC_W-1:0] sync_in;
    logic [PIMS_SYNC_W-1:0] sync_out;
    logic [7:1] ev_lvl;
    logic [7:1] ev_lvl_q;
    logic [7:1] ev_pulse;
    logic an_done_s;
    logic [2:0] spd_s;

    assign sync_in = {autoneg_done, speed_duplex, phy_event};

    pims_sync #(.WIDTH(PIMS_SYNC_W)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din(sync_in),
        .dout(sync_out)
    );

    assign ev_lvl = sync_out[PIMS_SYNC_EV_HI:PIMS_SYNC_EV_LO];
    assign spd_s = sync_out[PIMS_SYNC_SPD_HI:PIMS_SYNC_SPD_LO];
    assign an_done_s = sync_out[PIMS_SYNC_AN];

    // events are rising edges of the synchronised levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_lvl_q <= '0;
        end else begin
            ev_lvl_q <= ev_lvl;
        end
    end
    assign ev_pulse = ev_lvl & ~ev_lvl_q;

    // ********************************
    // interrupt enable register
    // ********************************
    logic [7:1] irq_enable;
    logic [7:1] flags;
    logic wr_enable;
    logic wr_special;
    logic rd_flags;

    assign wr_enable = reg_wr && (reg_index == PIMS_IDX_ENABLE);
    assign wr_special = reg_wr && (reg_index == PIMS_IDX_SPECIAL);
    assign rd_flags = reg_rd && (reg_index == PIMS_IDX_FLAGS);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable <= '0;
        end else if (wr_enable) begin
            irq_enable <= reg_wdata[PIMS_SRC_HI:PIMS_SRC_LO];
        end
    end

    pims_flags u_flags (
        .clk(clk),
        .rst_b(rst_b),
        .event_pulse(ev_pulse),
        .enable(irq_enable),
        .clear(rd_flags),
        .flags(flags)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phy_irq <= 1'b0;
        end else begin
            phy_irq <= |(flags & irq_enable);
        end
    end

    // ********************************
    // special control/status register
    // ********************************
    logic [6:0] rsv_field;
    logic [1:0] low_field;
    logic autodone;
    logic [2:0] speed;

    // reserved field keeps what software writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsv_field <= PIMS_RSV_RESET;
            low_field <= PIMS_LOW_RESET;
        end else if (wr_special) begin
            rsv_field <= reg_wdata[PIMS_RSV_HI:PIMS_RSV_LO];
            low_field <= reg_wdata[PIMS_LOW_HI:PIMS_LOW_LO];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            autodone <= 1'b0;
        end else begin
            autodone <= an_done_s;
        end
    end

    // reserved codes pass through as reported; only four are meaningful
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            speed <= PIMS_SPEED_RESET;
        end else begin
            speed <= spd_s;
        end
    end

    // ********************************
    // read mux
    // ********************************
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = PIMS_ZERO16;
        reg_hit = 1'b1;
        unique case (reg_index)
            PIMS_IDX_FLAGS: begin
                next_rdata[PIMS_SRC_HI:PIMS_SRC_LO] = flags;
            end
            PIMS_IDX_ENABLE: begin
                next_rdata[PIMS_SRC_HI:PIMS_SRC_LO] = irq_enable;
                next_rdata = next_rdata & PIMS_ENABLE_MASK;
            end
            PIMS_IDX_SPECIAL: begin
                next_rdata[PIMS_AUTODONE_BIT] = autodone;
                next_rdata[PIMS_RSV_HI:PIMS_RSV_LO] = rsv_field;
                next_rdata[PIMS_SPEED_HI:PIMS_SPEED_LO] = speed;
                next_rdata[PIMS_LOW_HI:PIMS_LOW_LO] = low_field;
            end
            default: begin
                reg_hit = 1'b0;
            end
        endcase
    end

    // data registered on a read strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= PIMS_ZERO16;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : pims_regs
`default_nettype wire

/* File: hw/pims_pkg.sv */
// constants for the port phy interrupt enable and special control/status registers
// Summary of operation
// - 16-bit read/write interrupt enable register at index 30, paired with flag register.
// - enable bit 7 gates the energy-detected flag; resets to 0.
// - enable bit 6 gates the auto-negotiation-complete flag; resets to 0.
// - enable bit 5 gates the remote-fault flag; resets to 0.
// - enable bit 4 gates the link-down flag; resets to 0.
// - enable bit 3 gates the partner-acknowledge flag; resets to 0.
// - enable bit 2 gates the parallel-detection-fault flag; resets to 0.
// - enable bit 1 gates the page-received flag; resets to 0.
// - 16-bit special control/status register at index 31.
// - bit 12 reads 1 once auto-negotiation completed, else 0; resets to 0.
// - bits 11:5 read/write reserved field resetting to 0000010b; software writes that.
// - bits 4:2 report speed/duplex codes 001,010,101,110; reset 000.
// - a source flag sets and stays set on its event while enabled.
// - reading the flag register clears every latched flag not set again by an enabled event in that same cycle.
package pims_pkg;
    // ********************************
    // register indices
    // ********************************
    localparam logic [4:0] PIMS_IDX_FLAGS = 5'h1d;
    localparam logic [4:0] PIMS_IDX_ENABLE = 5'h1e;
    localparam logic [4:0] PIMS_IDX_SPECIAL = 5'h1f;
    // ********************************
    // field layout
    // ********************************
    localparam logic [15:0] PIMS_ENABLE_MASK = 16'h00fe;
    localparam int PIMS_SRC_LO = 1;
    localparam int PIMS_SRC_HI = 7;
    localparam int PIMS_AUTODONE_BIT = 12;
    localparam int PIMS_RSV_LO = 5;
    localparam int PIMS_RSV_HI = 11;
    localparam int PIMS_SPEED_LO = 2;
    localparam int PIMS_SPEED_HI = 4;
    localparam int PIMS_LOW_LO = 0;
    localparam int PIMS_LOW_HI = 1;
    localparam logic [6:0] PIMS_RSV_RESET = 7'h02;
    localparam logic [2:0] PIMS_SPEED_RESET = 3'h0;
    localparam logic [1:0] PIMS_LOW_RESET = 2'h0;
    localparam logic [15:0] PIMS_ZERO16 = 16'h0000;
    // ********************************
    // pin synchroniser packing
    // ********************************
    localparam int PIMS_SYNC_W = 11;
    localparam int PIMS_SYNC_EV_LO = 0;
    localparam int PIMS_SYNC_EV_HI = 6;
    localparam int PIMS_SYNC_SPD_LO = 7;
    localparam int PIMS_SYNC_SPD_HI = 9;
    localparam int PIMS_SYNC_AN = 10;
    // speed/duplex codes
    localparam logic [2:0] PIMS_SPD_10_HALF = 3'h1;
    localparam logic [2:0] PIMS_SPD_100_HALF = 3'h2;
    localparam logic [2:0] PIMS_SPD_10_FULL = 3'h5;
    localparam logic [2:0] PIMS_SPD_100_FULL = 3'h6;
endpackage : pims_pkg

/* File: hw/pims_sync.sv */
// two flop synchroniser for pin level inputs
`timescale 1ns/10ps
`default_nettype none
module pims_sync
    import pims_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;
    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : pims_sync
`default_nettype wire

/* File: hw/pims_flags.sv */
// latched interrupt source flags with clear on read
`timescale 1ns/10ps
`default_nettype none
module pims_flags
    import pims_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // events and enables
    input wire logic [7:1] event_pulse,
    input wire logic [7:1] enable,
    input wire logic clear,
    // state
    output logic [7:1] flags
);
    genvar i;
    generate
        for (i = PIMS_SRC_LO; i <= PIMS_SRC_HI; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flags[i] <= 1'b0;
                end else if (event_pulse[i] && enable[i]) begin
                    // set beats a clear in the same cycle so no event is lost
                    flags[i] <= 1'b1;
                end else if (clear) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : pims_flags
`default_nettype wire

/* File: verification/pims_regs_sva.sv */
// assertions on the pims_regs ports
`timescale 1ns/10ps
`default_nettype none
module pims_regs_sva
    import pims_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [4:0] reg_index,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit,
    // phy side
    input wire logic [7:1] phy_event,
    input wire logic autoneg_done,
    input wire logic [2:0] speed_duplex,
    input wire logic phy_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    hit_decode_a: assert property (reg_hit == (reg_index >= PIMS_IDX_FLAGS))
        else $error("hit decode wrong");
    unmapped_zero_a: assert property (reg_rd && !reg_hit |=> reg_rdata == PIMS_ZERO16)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    enable_rsv_a: assert property (reg_rd && reg_index == PIMS_IDX_ENABLE |=>
        reg_rdata[15:8] == 8'h00 && !reg_rdata[0]) else $error("enable reserved set");
    irq_mask_a: assert property (reg_wr && reg_index == PIMS_IDX_ENABLE &&
        reg_wdata[7:1] == 7'h00 |-> ##2 !phy_irq) else $error("irq while masked");
    // pins held steady long enough to cover the synchroniser delay
    speed_track_a: assert property ($stable(speed_duplex) [*5] ##0
        (reg_rd && reg_index == PIMS_IDX_SPECIAL) |=> reg_rdata[4:2] == $past(speed_duplex))
        else $error("speed field wrong");
    autodone_track_a: assert property ($stable(autoneg_done) [*5] ##0
        (reg_rd && reg_index == PIMS_IDX_SPECIAL) |=> reg_rdata[12] == $past(autoneg_done))
        else $error("autodone wrong");
    clear_read_a: assert property ($stable(phy_event) [*6] ##0
        (reg_rd && reg_index == PIMS_IDX_FLAGS) |-> ##2 !phy_irq) else $error("flags kept");
    cover property (reg_rd && reg_index == PIMS_IDX_FLAGS && phy_irq);
    cover property ($rose(phy_irq));
    cover property (reg_wr && reg_index == PIMS_IDX_SPECIAL);
endmodule : pims_regs_sva
`default_nettype wire

/* File: verification/pims_phy_model.sv */
// phy status pin model
`timescale 1ns/10ps
`default_nettype none
module pims_phy_model (
    // clock
    input wire logic clk,
    // status pins
    output logic [7:1] phy_event = 7'h00,
    output logic autoneg_done = 1'h0,
    output logic [2:0] speed_duplex = 3'h0
);
    // one event per rise; held so the synchroniser cannot miss it
    task automatic pulse(input int n);
        @(negedge clk);
        phy_event[n] = 1'h1;
        repeat (3) @(negedge clk);
        phy_event[n] = 1'h0;
    endtask : pulse
    task automatic status(input logic a, input logic [2:0] s);
        @(negedge clk);
        autoneg_done = a;
        speed_duplex = s;
    endtask : status
endmodule : pims_phy_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the pims register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pims_pkg::*;
    logic clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [4:0] reg_index = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_hit, autoneg_done, phy_irq;
    logic [7:1] phy_event;
    logic [2:0] speed_duplex;
    int fail_count = 0;
    int tests_run = 0;
    logic [2:0] codes [4] = '{PIMS_SPD_10_HALF, PIMS_SPD_100_HALF, PIMS_SPD_10_FULL,
        PIMS_SPD_100_FULL};
    always #10 clk = ~clk;
    pims_regs pims_regs_inst (.clk(clk), .rst_b(rst_b), .reg_index(reg_index),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .phy_event(phy_event), .autoneg_done(autoneg_done),
        .speed_duplex(speed_duplex), .phy_irq(phy_irq));
    pims_phy_model pims_phy_model_inst (.clk(clk), .phy_event(phy_event),
        .autoneg_done(autoneg_done), .speed_duplex(speed_duplex));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        @(negedge clk);
        reg_index = i;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge clk);
        reg_wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [4:0] i, input logic [15:0] e);
        @(negedge clk);
        reg_index = i;
        reg_rd = 1'h1;
        @(negedge clk);
        reg_rd = 1'h0;
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic final_report;
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial begin
        // whole run needs well under a thousand cycles
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'h1;
        rd(PIMS_IDX_ENABLE, 16'h0000);
        rd(PIMS_IDX_SPECIAL, 16'h0040);
        rd(5'h05, 16'h0000);
        chk("reg_hit", 16'h0000, {15'h0000, reg_hit});
        wr(PIMS_IDX_ENABLE, 16'hffff);
        rd(PIMS_IDX_ENABLE, 16'h00fe);
        // reserved field always written with its required value
        wr(PIMS_IDX_SPECIAL, 16'hf05f);
        rd(PIMS_IDX_SPECIAL, 16'h0043);
        wr(PIMS_IDX_SPECIAL, 16'h0040);
        for (int i = 0; i < 4; i++) begin
            pims_phy_model_inst.status(1'h1, codes[i]);
            repeat (5) @(negedge clk);
            rd(PIMS_IDX_SPECIAL, {4'h1, PIMS_RSV_RESET, codes[i], 2'h0});
        end
        pims_phy_model_inst.status(1'h0, 3'h0);
        repeat (5) @(negedge clk);
        rd(PIMS_IDX_SPECIAL, 16'h0040);
        // one source enabled, a neighbour pulsed while masked
        for (int n = 1; n < 8; n++) begin
            wr(PIMS_IDX_ENABLE, 16'h0001 << n);
            pims_phy_model_inst.pulse(n == 7 ? 1 : n + 1);
            // first pass clears by reading while enabled, second by masking
            for (int k = 0; k < 2; k++) begin
                pims_phy_model_inst.pulse(n);
                repeat (6) @(negedge clk);
                chk("phy_irq", 16'h0001, {15'h0000, phy_irq});
                if (k == 0) begin
                    rd(PIMS_IDX_FLAGS, 16'h0001 << n);
                end else begin
                    wr(PIMS_IDX_ENABLE, 16'h0000);
                end
                repeat (2) @(negedge clk);
                chk("phy_irq", 16'h0000, {15'h0000, phy_irq});
            end
            rd(PIMS_IDX_FLAGS, 16'h0001 << n);
            rd(PIMS_IDX_FLAGS, 16'h0000);
        end
        // a write to the read-only flag index must not reach the enables
        wr(PIMS_IDX_FLAGS, 16'h00fe);
        rd(PIMS_IDX_ENABLE, 16'h0000);
        // reset in mid-run brings back the reset values
        wr(PIMS_IDX_ENABLE, 16'h00fe);
        wr(PIMS_IDX_SPECIAL, 16'h0041);
        @(negedge clk);
        rst_b = 1'h0;
        repeat (3) @(negedge clk);
        rst_b = 1'h1;
        rd(PIMS_IDX_ENABLE, 16'h0000);
        rd(PIMS_IDX_SPECIAL, 16'h0040);
        final_report();
    end
endmodule : tb_top
bind pims_regs pims_regs_sva pims_regs_sva_inst (.clk(clk), .rst_b(rst_b),
    .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .phy_event(phy_event),
    .autoneg_done(autoneg_done), .speed_duplex(speed_duplex), .phy_irq(phy_irq));
`default_nettype wire
